// ==== design/gate_drive_config_and_fault_regs.sv ====
// Summary of operation
// - High-side gate faults in bits 10,8,6
// - Low-side gate faults in bits 9,7,5
// - Control register writable, bits 9:0 read back last write
// - Read, clear-faults, gate-enable reset keep config
// - Power-up loads config defaults
// - Sleep entry restores config defaults
// - Source time field bits 9:8, default 3
// - Sink current field bits 7:4, default 4
// - Source current field bits 3:0, default 4
// - Response: five don't-care bits, eleven data
`timescale 1ns/10ps
`default_nettype none
`include "gate_drive_map.svh"

module gate_drive_config_and_fault_regs #(
    parameter int FRAME_LEN = `FRAME_BITS
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic sclk,
    input wire logic csN,
    input wire logic mosi,
    output logic miso,
    output logic misoOe,
    input wire logic sleepEntry,
    input wire logic clearFaultsCmd,
    input wire logic gateEnableReset,
    input wire gate_drive_pkg::fault_vec_type faultIn,
    output logic [1:0] hsPeakSourceTime,
    output logic [3:0] hsPeakSinkCode,
    output logic [3:0] hsPeakSourceCode,
    output logic [11:0] hsSourceTimeNs,
    output logic [10:0] hsSinkMilliAmp,
    output logic [10:0] hsSourceMilliAmp
);

    // ==========================================================
    // Elaboration check
    // The link logic counts to a fixed sixteen edges
    if (FRAME_LEN != `FRAME_BITS) begin : gen_bad_frame
        $error("Only sixteen-bit frames are supported");
    end

    // ==========================================================
    // Clock-domain state
    logic linkRst; // Registered reset, async reset of link side
    gate_drive_pkg::reg_data_type hsConfig; // Live config
    gate_drive_pkg::fault_vec_type faultFlags; // Sticky faults
    gate_drive_pkg::reg_data_type snapConfig; // Frozen for reads
    gate_drive_pkg::reg_data_type snapFault; // Frozen for reads
    logic [2:0] csSync; // Chip select synchroniser
    logic [2:0] togSync; // Write toggle synchroniser
    logic togSeen; // Last accepted toggle level

    // ==========================================================
    // Link-domain state
    logic [4:0] rxCount; // Falling edges this frame
    logic [4:0] txCount; // Rising edges this frame
    logic [15:0] rxShift; // Incoming bits, newest at bit 0
    logic [15:0] holdWord; // Last complete frame
    logic writeToggle; // Flips once per complete frame
    logic [9:0] txShift; // Remaining response bits

    // ==========================================================
    // Decode of the word handed over from the link
    wire frameDone = (togSync[1] == togSync[2]) &&
                     (togSync[2] != togSeen);
    wire isWrite = (holdWord[`RW_BIT] != `READ_FLAG);
    wire gate_drive_pkg::reg_addr_type holdAddr =
        holdWord[`ADDR_HI:`ADDR_LO];
    wire cfgWrite = frameDone && isWrite &&
                    (holdAddr == `ADDR_HS_CONFIG);
    // Bit 10 is reserved and never stored
    wire gate_drive_pkg::reg_data_type writeData =
        {1'h0, holdWord[9:0]};
    wire gate_drive_pkg::reg_data_type defaultConfig =
        {1'h0, `SRC_TIME_DEFAULT, `SINK_DEFAULT, `SRC_DEFAULT};
    // Chip select seen idle by both later stages
    wire csIdle = csSync[1] && csSync[2];

    // Fault register image, reserved low bits zero
    wire gate_drive_pkg::reg_data_type faultImage = {
        faultFlags[5], // High A
        faultFlags[4], // Low A
        faultFlags[3], // High B
        faultFlags[2], // Low B
        faultFlags[1], // High C
        faultFlags[0], // Low C
        5'h00 // Reserved reads zero
    };

    // Decoded drive strengths from the live fields
    wire [1:0] timeCode = hsConfig[`SRC_TIME_HI:`SRC_TIME_LO];
    wire [3:0] sinkCode = hsConfig[`SINK_HI:`SINK_LO];
    wire [3:0] srcCode = hsConfig[`SRC_HI:`SRC_LO];

    // Source time code to nanoseconds
    function automatic logic [11:0] time_ns(input logic [1:0] c);
        case (c)
            2'h0: time_ns = `TIME_CODE0_NS;
            2'h1: time_ns = `TIME_CODE1_NS;
            2'h2: time_ns = `TIME_CODE2_NS;
            default: time_ns = `TIME_CODE3_NS;
        endcase
    endfunction

    // Current code to milliamps: linear low range, a first
    // strong level of its own, then even strong steps measured
    // from an origin code, spare codes fixed at one level
    function automatic logic [10:0] drive_ma(
        input logic [3:0] c,
        input logic [10:0] base,
        input logic [10:0] step,
        input logic [10:0] first,
        input logic [10:0] highStep,
        input logic [10:0] origin,
        input logic [10:0] spare
    );
        logic [10:0] code;
        code = {7'h00, c};
        if (c <= `LOW_RANGE_TOP) begin
            // Weak range, one small step per code
            drive_ma = 11'(base + code * step);
        end else if (c == `FIRST_HIGH_CODE) begin
            // The source side's first strong level is half a
            // step, so no single formula covers both fields
            drive_ma = first;
        end else if (c <= `HIGH_RANGE_TOP) begin
            // Strong range, even steps from the origin code
            drive_ma = 11'((code - origin) * highStep);
        end else begin
            // Codes above the table alias to one safe level
            drive_ma = spare;
        end
    endfunction

    // Decoded values are registered below, so the multiply
    // path only has to settle within one clock
    wire [11:0] next_timeNs = time_ns(timeCode);
    wire [10:0] next_sinkMa = drive_ma(sinkCode, `SINK_BASE_MA,
        `SINK_STEP_MA, `SINK_FIRST_HIGH_MA, `SINK_HIGH_STEP_MA,
        `SINK_HIGH_ORIGIN, `SINK_SPARE_MA);
    wire [10:0] next_srcMa = drive_ma(srcCode, `SRC_BASE_MA,
        `SRC_STEP_MA, `SRC_FIRST_HIGH_MA, `SRC_HIGH_STEP_MA,
        `SRC_HIGH_ORIGIN, `SRC_SPARE_MA);

    // ==========================================================
    // Link reset, registered so the link side sees a clean level
    // It is released while sclk stands still, so the link flops
    // never see a clock edge close to the release
    always_ff @(posedge clk) begin
        linkRst <= srst;
    end

    // ==========================================================
    // Synchronisers: three stages, second and third must agree
    always_ff @(posedge clk) begin
        if (srst) begin
            // Idle levels, so no false edge follows reset
            csSync <= 3'h7;
            togSync <= 3'h0;
        end else begin
            // Oldest sample sits in the top stage
            csSync <= {csSync[1:0], csN};
            togSync <= {togSync[1:0], writeToggle};
        end
    end

    // Accept each new toggle level once
    always_ff @(posedge clk) begin
        if (srst) begin
            togSeen <= 1'h0;
        end else if (frameDone) begin
            // Remember the level just taken
            togSeen <= togSync[2];
        end
    end

    // ==========================================================
    // Config register: reset and sleep load defaults, only a
    // write to its address changes it
    always_ff @(posedge clk) begin
        if (srst) begin
            hsConfig <= defaultConfig;
        end else if (sleepEntry) begin
            hsConfig <= defaultConfig;
        end else if (cfgWrite) begin
            // Only a complete write to this address lands
            hsConfig <= writeData;
        end
        // Reads, clear-faults and gate-enable reset fall through
        // and leave the fields alone
    end

    // Sticky faults: a new fault beats a clear in the same cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            faultFlags <= 6'h00;
        end else if (clearFaultsCmd || gateEnableReset) begin
            // Clear, but a fault present now survives it
            faultFlags <= faultIn;
        end else begin
            // Flags hold until cleared
            faultFlags <= faultFlags | faultIn;
        end
    end

    // Snapshot for the link, frozen while a frame runs so the
    // link side never samples a word in motion
    always_ff @(posedge clk) begin
        if (srst) begin
            snapConfig <= defaultConfig;
            snapFault <= 11'h000;
        end else if (csIdle) begin
            // Follow the live values only between frames
            snapConfig <= hsConfig;
            snapFault <= faultImage;
        end
    end

    // ==========================================================
    // Outputs to the drive stage, all registered
    always_ff @(posedge clk) begin
        if (srst) begin
            hsPeakSourceTime <= `SRC_TIME_DEFAULT;
            hsPeakSinkCode <= `SINK_DEFAULT;
            hsPeakSourceCode <= `SRC_DEFAULT;
            hsSourceTimeNs <= `TIME_CODE3_NS;
            // Decodes follow one clock after release
            hsSinkMilliAmp <= 11'h000;
            hsSourceMilliAmp <= 11'h000;
            misoOe <= 1'h0;
        end else begin
            hsPeakSourceTime <= timeCode;
            hsPeakSinkCode <= sinkCode;
            hsPeakSourceCode <= srcCode;
            hsSourceTimeNs <= next_timeNs;
            hsSinkMilliAmp <= next_sinkMa;
            hsSourceMilliAmp <= next_srcMa;
            // Drive only once two stages agree the frame is open;
            // a glitch on the select pin then never reaches miso
            misoOe <= !csSync[1] && !csSync[2];
        end
    end

    // ==========================================================
    // Link receive: sample on falling edges, count per frame
    always_ff @(negedge sclk or posedge csN) begin
        if (csN) begin
            // A deselect abandons any part-received word
            rxCount <= 5'h00;
            rxShift <= 16'h0000;
        end else begin
            rxCount <= 5'(rxCount + 5'h01);
            // Newest bit enters at the bottom
            rxShift <= {rxShift[14:0], mosi};
        end
    end

    // Hand a complete frame over by a toggle; the word stays put
    // until the next frame completes
    always_ff @(negedge sclk or posedge linkRst) begin
        if (linkRst) begin
            holdWord <= 16'h0000;
            writeToggle <= 1'h0;
        end else if (rxCount == `LAST_FRAME_EDGE) begin
            // Sixteenth falling edge: the word is whole; shorter
            // frames never get here and are dropped
            holdWord <= {rxShift[14:0], mosi};
            writeToggle <= ~writeToggle;
        end
    end

    // ==========================================================
    // Link transmit: address is known after five falling edges
    wire gate_drive_pkg::reg_addr_type rxAddr = rxShift[3:0];
    wire gate_drive_pkg::reg_data_type readWord =
        (rxAddr == `ADDR_HS_CONFIG) ? snapConfig :
        (rxAddr == `ADDR_FAULT_STATUS) ? snapFault : 11'h000;

    always_ff @(posedge sclk or posedge csN) begin
        if (csN) begin
            txCount <= 5'h00;
            // Deselect ends any response under way
            txShift <= 10'h000;
            miso <= 1'h0;
        end else begin
            txCount <= 5'(txCount + 5'h01);
            if (txCount < 5'(`RESP_DATA_EDGE)) begin
                miso <= 1'h0; // Upper five bits don't care
            end else if (txCount == 5'(`RESP_DATA_EDGE)) begin
                // Address is complete: load the frozen register
                miso <= readWord[`DATA_HI];
                txShift <= readWord[9:0];
            end else begin
                // Shift the rest out, most significant first
                miso <= txShift[9];
                txShift <= {txShift[8:0], 1'h0};
            end
        end
    end

endmodule
`default_nettype wire

// ==== design/gate_drive_map.svh ====
`ifndef GATE_DRIVE_MAP_SVH
`define GATE_DRIVE_MAP_SVH

// ==========================================================
// Link word layout
`define FRAME_BITS 16
`define RW_BIT 15
`define ADDR_HI 14
`define ADDR_LO 11
`define DATA_HI 10
`define RESP_DATA_EDGE 5
`define LAST_FRAME_EDGE 5'h0F
`define READ_FLAG 1'h1

// ==========================================================
// Register addresses
`define ADDR_FAULT_STATUS 4'h4
`define ADDR_HS_CONFIG 4'h5

// ==========================================================
// Fault status bit positions
`define FAULT_HIGH_A 10
`define FAULT_LOW_A 9
`define FAULT_HIGH_B 8
`define FAULT_LOW_B 7
`define FAULT_HIGH_C 6
`define FAULT_LOW_C 5

// ==========================================================
// High-side config fields and defaults
`define SRC_TIME_HI 9
`define SRC_TIME_LO 8
`define SINK_HI 7
`define SINK_LO 4
`define SRC_HI 3
`define SRC_LO 0
`define SRC_TIME_DEFAULT 2'h3
`define SINK_DEFAULT 4'h4
`define SRC_DEFAULT 4'h4

// ==========================================================
// Decoded drive strengths: ns and mA
`define TIME_CODE0_NS 12'h0DC
`define TIME_CODE1_NS 12'h1B8
`define TIME_CODE2_NS 12'h370
`define TIME_CODE3_NS 12'h6F4
`define LOW_RANGE_TOP 4'h6
`define FIRST_HIGH_CODE 4'h7
`define HIGH_RANGE_TOP 4'hB
`define SINK_STEP_MA 11'h00A
`define SINK_BASE_MA 11'h014
`define SINK_FIRST_HIGH_MA 11'h0FA
`define SINK_HIGH_STEP_MA 11'h0FA
`define SINK_HIGH_ORIGIN 11'h006
`define SINK_SPARE_MA 11'h03C
`define SRC_STEP_MA 11'h00A
`define SRC_BASE_MA 11'h00A
`define SRC_FIRST_HIGH_MA 11'h07D
`define SRC_HIGH_STEP_MA 11'h0FA
`define SRC_HIGH_ORIGIN 11'h007
`define SRC_SPARE_MA 11'h032

`endif

// ==== design/gate_drive_pkg.sv ====
package gate_drive_pkg;
    // Register address on the link
    typedef logic [3:0] reg_addr_type;
    // Eleven data bits of any register
    typedef logic [10:0] reg_data_type;
    // Six gate-source fault flags, high A first
    typedef logic [5:0] fault_vec_type;
endpackage

// ==== sim/gate_drive_config_and_fault_regs_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module gate_drive_config_and_fault_regs_tb;
    logic clk, srst, sclk, csN, mosi, miso, misoOe, misoLine;
    logic sleepEntry, clearFaultsCmd, gateEnableReset;
    gate_drive_pkg::fault_vec_type faultIn;
    logic [1:0] hsPeakSourceTime;
    logic [3:0] hsPeakSinkCode, hsPeakSourceCode;
    logic [11:0] hsSourceTimeNs, seen;
    logic [10:0] hsSinkMilliAmp, hsSourceMilliAmp;
    logic [11:0] expQ[$];
    logic [15:0] resp;
    logic [31:0] rnd;
    int mismatches, checked, cycles;
    event gotResult;
    // Undriven line shows the inverse, never a held value
    assign misoLine = misoOe ? miso : ~miso;
    gate_drive_config_and_fault_regs u_gate_drive_config_and_fault_regs (
        .clk, .srst, .sclk, .csN, .mosi, .miso, .misoOe, .sleepEntry,
        .clearFaultsCmd, .gateEnableReset, .faultIn, .hsPeakSourceTime,
        .hsPeakSinkCode, .hsPeakSourceCode, .hsSourceTimeNs,
        .hsSinkMilliAmp, .hsSourceMilliAmp);
    spi_host_model u_spi_host_model (.sclk, .csN, .mosi, .miso(misoLine));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            complete_run();
        end
    end
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Note the expectation, then hand the result to the watcher
    task automatic note(input logic [11:0] got, input logic [11:0] exp);
        expQ.push_back(exp);
        seen = got;
        ->gotResult;
        #1;
    endtask
    initial forever begin
        @(gotResult);
        cmp(seen, expQ.pop_front());
    end
    task automatic link_write(input logic [3:0] a, input logic [10:0] d);
        u_spi_host_model.xfer({1'b0, a, d}, resp);
        repeat (3) @(posedge clk);
    endtask
    task automatic link_read(input logic [3:0] a, input logic [10:0] e);
        u_spi_host_model.xfer({1'b1, a, 11'h0}, resp);
        note({1'b0, resp[10:0]}, {1'b0, e});
    endtask
    task automatic strobe(input logic [2:0] s);
        @(posedge clk);
        #2 {sleepEntry, clearFaultsCmd, gateEnableReset} = s;
        @(posedge clk);
        #2 {sleepEntry, clearFaultsCmd, gateEnableReset} = 3'h0;
    endtask
    task automatic check_codes(input logic [10:0] d);
        repeat (4) @(posedge clk);
        // Sample off the edge, where the outputs have settled
        #2;
        note({2'h0, hsPeakSourceTime, hsPeakSinkCode, hsPeakSourceCode},
            {2'h0, d[9:0]});
        note(hsSourceTimeNs, gd_expect_pkg::time_ns(d[9:8]));
        note({1'b0, hsSinkMilliAmp},
            {1'b0, gd_expect_pkg::sink_ma(d[7:4])});
        note({1'b0, hsSourceMilliAmp},
            {1'b0, gd_expect_pkg::src_ma(d[3:0])});
    endtask
    task automatic complete_run();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        logic [10:0] data;
        logic [5:0] fpat;
        srst = 1'b1;
        faultIn = 6'h0;
        {sleepEntry, clearFaultsCmd, gateEnableReset} = 3'h0;
        rnd = 32'h14;
        repeat (10) @(posedge clk);
        #2 srst = 1'b0;
        check_codes(11'h344);
        link_read(4'h5, 11'h344);
        // Every sink and source code, random reserved bit
        for (int i = 0; i < 16; i++) begin
            rnd = xorshift(rnd);
            data = {rnd[10], i[1:0], i[3:0], 4'hF - i[3:0]};
            link_write(4'h5, data);
            check_codes(data);
            link_read(4'h5, {1'b0, data[9:0]});
        end
        strobe(3'h3);
        link_read(4'h5, {1'b0, data[9:0]});
        for (int p = 0; p < 2; p++) begin
            fpat = p ? 6'h15 : 6'h2A;
            @(posedge clk);
            #2 faultIn = fpat;
            @(posedge clk);
            #2 faultIn = 6'h0;
            link_write(4'h4, 11'h7FF);
            link_read(4'h4, {fpat, 5'h0});
            strobe(p ? 3'h1 : 3'h2);
            link_read(4'h4, 11'h0);
        end
        link_read(4'h9, 11'h0);
        strobe(3'h4);
        check_codes(11'h344);
        link_read(4'h5, 11'h344);
        complete_run();
    end
endmodule
bind gate_drive_config_and_fault_regs gate_drive_monitor u_gate_drive_monitor (
    .clk, .srst, .sclk, .csN, .miso, .misoOe, .sleepEntry, .hsPeakSourceTime,
    .hsPeakSinkCode, .hsPeakSourceCode, .hsSourceTimeNs, .hsSinkMilliAmp,
    .hsSourceMilliAmp);
`default_nettype wire

// ==== sim/gate_drive_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module gate_drive_monitor (
    input wire logic clk,
    input wire logic srst,
    input wire logic sclk,
    input wire logic csN,
    input wire logic miso,
    input wire logic misoOe,
    input wire logic sleepEntry,
    input wire logic [1:0] hsPeakSourceTime,
    input wire logic [3:0] hsPeakSinkCode,
    input wire logic [3:0] hsPeakSourceCode,
    input wire logic [11:0] hsSourceTimeNs,
    input wire logic [10:0] hsSinkMilliAmp,
    input wire logic [10:0] hsSourceMilliAmp
);
    // Rising link edges seen in the current frame
    logic [4:0] edgeCount;
    always_ff @(posedge sclk or posedge csN) begin
        if (csN) edgeCount <= 5'h0;
        else edgeCount <= edgeCount + 5'h1;
    end
    wire logic defaultsSet = hsPeakSourceTime == 2'h3 &&
        hsPeakSinkCode == 4'h4 && hsPeakSourceCode == 4'h4;
    sequence resetHeld; srst[*2]; endsequence
    // Idle link, no sleep: nothing may move the config
    sequence quietRun; (csN && !sleepEntry)[*8]; endsequence
    // ==========================================================
    // Checks
    reset_defaults_a: assert property (@(posedge clk)
        resetHeld |=> defaultsSet) else $error("no defaults after reset");
    sleep_defaults_a: assert property (@(posedge clk)
        disable iff (srst) sleepEntry |-> ##2 defaultsSet)
        else $error("no defaults on sleep");
    time_decode_a: assert property (@(posedge clk) disable iff (srst)
        !$past(srst) && $stable(hsPeakSourceTime) |->
        hsSourceTimeNs == gd_expect_pkg::time_ns(hsPeakSourceTime))
        else $error("source time decode wrong");
    sink_decode_a: assert property (@(posedge clk) disable iff (srst)
        !$past(srst) && $stable(hsPeakSinkCode) |->
        hsSinkMilliAmp == gd_expect_pkg::sink_ma(hsPeakSinkCode))
        else $error("sink current decode wrong");
    source_decode_a: assert property (@(posedge clk) disable iff (srst)
        !$past(srst) && $stable(hsPeakSourceCode) |->
        hsSourceMilliAmp == gd_expect_pkg::src_ma(hsPeakSourceCode))
        else $error("source current decode wrong");
    miso_idle_a: assert property (@(posedge clk) disable iff (srst)
        csN[*5] |-> !misoOe && !miso) else $error("output driven while idle");
    oe_delay_a: assert property (@(posedge clk) disable iff (srst)
        $fell(csN) |-> (!misoOe)[*2] ##[1:3] misoOe)
        else $error("output enable timing wrong");
    header_zero_a: assert property (@(negedge sclk) disable iff (srst)
        !csN && edgeCount < 5'h6 |-> !miso) else $error("header bits not 0");
    config_hold_a: assert property (@(posedge clk) disable iff (srst)
        quietRun |=> $stable(hsPeakSourceTime) && $stable(hsPeakSinkCode) &&
        $stable(hsPeakSourceCode)) else $error("config moved while idle");
endmodule
`default_nettype wire

// ==== sim/gd_expect_pkg.sv ====
`default_nettype none
package gd_expect_pkg;
    // Peak source time in ns for each code
    function automatic logic [11:0] time_ns(input logic [1:0] c);
        return c[1] ? (c[0] ? 12'h6F4 : 12'h370) : (c[0] ? 12'h1B8 : 12'hDC);
    endfunction
    // Sink current in mA; top codes fall back to 60
    function automatic logic [10:0] sink_ma(input logic [3:0] c);
        return c < 4'h7 ? 11'h14 + 11'(c) * 11'hA :
            c < 4'hC ? 11'(c - 4'h6) * 11'hFA : 11'h3C;
    endfunction
    // Source current in mA; code 7 is the odd 125 step
    function automatic logic [10:0] src_ma(input logic [3:0] c);
        return c < 4'h7 ? 11'hA + 11'(c) * 11'hA : c == 4'h7 ? 11'h7D :
            c < 4'hC ? 11'(c - 4'h7) * 11'hFA : 11'h32;
    endfunction
endpackage
`default_nettype wire

// ==== sim/spi_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Link master: data set after the rise, taken on the fall
module spi_host_model (
    output logic sclk,
    output logic csN,
    output logic mosi,
    input wire logic miso
);
    initial begin
        sclk = 1'b0;
        csN = 1'b1;
        mosi = 1'b0;
    end
    // One 16-bit word; clock stands still outside the frame
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        csN = 1'b0;
        #240;
        for (int i = 15; i >= 0; i--) begin
            sclk = 1'b1;
            #1 mosi = w[i];
            #5 sclk = 1'b0;
            r[i] = miso;
            #6;
        end
        #10 mosi = ~mosi;
        // Gap keeps the read snapshot time above its minimum
        csN = 1'b1;
        #240;
    endtask
endmodule
`default_nettype wire
